// [include/clock_source_pkg.sv]
// Package: register map, field layout and source codes for the clock source selector
package clock_source_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_PLL_REF_DSP = 8'h0d;
  localparam logic [7:0] ADDR_DAC_OSR = 8'h0e;
  localparam logic [7:0] ADDR_PUMP = 8'h0f;
  localparam logic [7:0] ADDR_DSP_DAC_PIN = 8'h10;
  localparam logic [7:0] ADDR_OSR_PUMP_PIN = 8'h11;
  localparam logic [7:0] ADDR_PLL_REF_PIN = 8'h12;

  // Field positions (low bit of each field)
  localparam int REF_SEL_LSB = 4;
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 4;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // Writable bit masks (reserved bits read zero)
  localparam logic [7:0] MASK_PLL_REF_DSP = 8'h17;
  localparam logic [7:0] MASK_TWO_FIELDS = 8'h77;
  localparam logic [7:0] MASK_LOW_FIELD = 8'h07;

  // Clock lines as they arrive at the selector, one bit each
  typedef struct packed {
    logic master_pin;
    logic bit_clk_pin;
    logic pll;
    logic osc;
    logic dac;
    logic serial_out_pin;
  } clk_sources_t;

  // Destination clocks produced by the selector
  typedef struct packed {
    logic pll_ref;
    logic dsp;
    logic dac;
    logic oversample;
    logic pump;
  } clk_outputs_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Selector source codes shared by the DSP and DAC dividers
  localparam logic [2:0] SRC_AUTO = 3'h0;
  localparam logic [2:0] SRC_PLL = 3'h1;
  localparam logic [2:0] SRC_OSC = 3'h2;
  localparam logic [2:0] SRC_MPIN = 3'h3;
  localparam logic [2:0] SRC_BPIN = 3'h4;
  localparam logic [2:0] SRC_GPIN = 3'h5;

  // Codes for the oversampling and charge-pump dividers
  localparam logic [2:0] SRC2_DAC = 3'h0;
  localparam logic [2:0] SRC2_AUTO = 3'h1;
  localparam logic [2:0] SRC2_PLL = 3'h2;
  localparam logic [2:0] SRC2_OSC = 3'h3;
  localparam logic [2:0] SRC2_MPIN = 3'h4;
  localparam logic [2:0] SRC2_BPIN = 3'h5;
  localparam logic [2:0] SRC2_GPIN = 3'h6;

  // PLL reference codes (3-bit view used by the automatic setup path)
  localparam logic [2:0] REF_MPIN = 3'h0;
  localparam logic [2:0] REF_BPIN = 3'h1;
  localparam logic [2:0] REF_OSC = 3'h2;
  localparam logic [2:0] REF_GPIN = 3'h3;

  // Pin-path code that routes the serial data out pin
  localparam logic [2:0] PIN_SERIAL_OUT = 3'h5;

  // Cycles spent in the gap state on a source change; the output stays low four cycles in all
  localparam logic [1:0] SWITCH_GAP_CYCLES = 2'h2;

endpackage : clock_source_pkg

// [rtl/glitch_free_mux.sv]
// One destination clock: glitch-free change of source with a low gap
`timescale 1ns/10ps
module glitch_free_mux
  import clock_source_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sel_i,
  input wire logic sel_valid_i,
  input wire logic src_level_i,
  output logic clk_o
);

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_GAP = 2'b01,
    ST_LOAD = 2'b11
  } sw_state_t;

  sw_state_t state_reg, state_next;
  logic [2:0] sel_reg, sel_next;
  logic [1:0] gap_reg, gap_next;
  logic out_reg, out_next;

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    gap_next = gap_reg;
    out_next = 1'b0;
    case (state_reg)
      ST_RUN: begin
        // A new code forces the output low before the new source is taken
        if (sel_i != sel_reg) begin
          state_next = ST_GAP;
          gap_next = SWITCH_GAP_CYCLES;
        end else begin
          out_next = src_level_i & sel_valid_i;
        end
      end
      ST_GAP: begin
        if (gap_reg <= 2'h1) begin
          state_next = ST_LOAD;
        end else begin
          gap_next = gap_reg - 2'h1;
        end
      end
      ST_LOAD: begin
        sel_next = sel_i;
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RUN;
      sel_reg <= 3'h0;
      gap_reg <= 2'h0;
      out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      gap_reg <= gap_next;
      out_reg <= out_next;
    end
  end

  assign clk_o = out_reg;

endmodule : glitch_free_mux

// [rtl/clock_source_select.sv]
// Clock source selector: select registers and the five destination clock muxes
//
// What this block does
// R1: Bit 4 of the first register picks the master clock pin (0) or bit clock pin (1) for the PLL.
// R2: In automatic clock setup the PLL reference setting is ignored and the auto choice is used.
// R3: PLL reference code 010 means oscillator, 011 means pin path, codes 100 to 111 mute it.
// R4: DSP divider field bits 2-0 pick auto master, PLL, oscillator, master pin, bit clock, pin path.
// R5: The auto master source picks the PLL or master pin when present, else the oscillator.
// R6: DAC divider field bits 6-4 uses the DSP code table and mutes on other codes.
// R7: Oversampling field picks DAC clock, auto, PLL, oscillator, master pin, bit clock, pin path.
// R8: Charge-pump field uses 000 to 110 in the same order as the oversampling field.
// R9: The oversampling and charge-pump pin path uses its own field of the pin register at 0x11.
// R10: DSP and DAC pin-source fields route the serial out pin on 101 and mute otherwise.
// R11: The PLL reference pin-source field routes the serial out pin on 101 and mutes otherwise.
// R12: A change of any select code (not a pin-source field) gates the output low so no runt pulse appears.
`timescale 1ns/10ps
module clock_source_select
  import clock_source_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire reg_req_t req_i,
  output logic [7:0] rdata_o,
  input wire clk_sources_t src_i,
  input wire logic auto_setup_i,
  input wire logic [2:0] auto_ref_sel_i,
  input wire logic master_present_i,
  output clk_outputs_t clk_o
);

  logic [7:0] ref_dsp_reg, ref_dsp_next;
  logic [7:0] dac_osr_reg, dac_osr_next;
  logic [7:0] pump_reg, pump_next;
  logic [7:0] dsp_dac_pin_reg, dsp_dac_pin_next;
  logic [7:0] osr_pump_pin_reg, osr_pump_pin_next;
  logic [7:0] ref_pin_reg, ref_pin_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    ref_dsp_next = ref_dsp_reg;
    dac_osr_next = dac_osr_reg;
    pump_next = pump_reg;
    dsp_dac_pin_next = dsp_dac_pin_reg;
    osr_pump_pin_next = osr_pump_pin_reg;
    ref_pin_next = ref_pin_reg;
    rdata_next = rdata_reg;
    if (req_i.wr) begin
      case (req_i.addr)
        ADDR_PLL_REF_DSP: ref_dsp_next = req_i.wdata & MASK_PLL_REF_DSP;
        ADDR_DAC_OSR: dac_osr_next = req_i.wdata & MASK_TWO_FIELDS;
        ADDR_PUMP: pump_next = req_i.wdata & MASK_LOW_FIELD;
        ADDR_DSP_DAC_PIN: dsp_dac_pin_next = req_i.wdata & MASK_TWO_FIELDS;
        ADDR_OSR_PUMP_PIN: osr_pump_pin_next = req_i.wdata & MASK_TWO_FIELDS;
        ADDR_PLL_REF_PIN: ref_pin_next = req_i.wdata & MASK_LOW_FIELD;
        default: ;
      endcase
    end
    if (req_i.rd) begin
      case (req_i.addr)
        ADDR_PLL_REF_DSP: rdata_next = ref_dsp_reg;
        ADDR_DAC_OSR: rdata_next = dac_osr_reg;
        ADDR_PUMP: rdata_next = pump_reg;
        ADDR_DSP_DAC_PIN: rdata_next = dsp_dac_pin_reg;
        ADDR_OSR_PUMP_PIN: rdata_next = osr_pump_pin_reg;
        ADDR_PLL_REF_PIN: rdata_next = ref_pin_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_dsp_reg <= REG_RESET;
      dac_osr_reg <= REG_RESET;
      pump_reg <= REG_RESET;
      dsp_dac_pin_reg <= REG_RESET;
      osr_pump_pin_reg <= REG_RESET;
      ref_pin_reg <= REG_RESET;
      rdata_reg <= REG_RESET;
    end else begin
      ref_dsp_reg <= ref_dsp_next;
      dac_osr_reg <= dac_osr_next;
      pump_reg <= pump_next;
      dsp_dac_pin_reg <= dsp_dac_pin_next;
      osr_pump_pin_reg <= osr_pump_pin_next;
      ref_pin_reg <= ref_pin_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // Field views
  logic [2:0] dsp_sel, dac_sel, osr_sel, pump_sel;
  logic [2:0] dsp_pin, dac_pin, osr_pin, pump_pin, ref_pin;
  assign dsp_sel = ref_dsp_reg[LOW_FIELD_LSB +: 3];
  assign dac_sel = dac_osr_reg[HIGH_FIELD_LSB +: 3];
  assign osr_sel = dac_osr_reg[LOW_FIELD_LSB +: 3];
  assign pump_sel = pump_reg[LOW_FIELD_LSB +: 3];
  assign dsp_pin = dsp_dac_pin_reg[HIGH_FIELD_LSB +: 3];
  assign dac_pin = dsp_dac_pin_reg[LOW_FIELD_LSB +: 3];
  assign pump_pin = osr_pump_pin_reg[HIGH_FIELD_LSB +: 3];
  assign osr_pin = osr_pump_pin_reg[LOW_FIELD_LSB +: 3];
  assign ref_pin = ref_pin_reg[LOW_FIELD_LSB +: 3];

  // Pin path per destination; a non-serial-out code leaves the path muted
  logic dsp_gpin, dac_gpin, osr_gpin, pump_gpin, ref_gpin;
  assign dsp_gpin = (dsp_pin == PIN_SERIAL_OUT) & src_i.serial_out_pin; // R10
  assign dac_gpin = (dac_pin == PIN_SERIAL_OUT) & src_i.serial_out_pin; // R10
  assign osr_gpin = (osr_pin == PIN_SERIAL_OUT) & src_i.serial_out_pin; // R9
  assign pump_gpin = (pump_pin == PIN_SERIAL_OUT) & src_i.serial_out_pin; // R9
  assign ref_gpin = (ref_pin == PIN_SERIAL_OUT) & src_i.serial_out_pin; // R11

  // Auto master: PLL or master pin when the master clock is seen, else oscillator
  logic auto_master;
  assign auto_master = master_present_i ? (src_i.pll | src_i.master_pin) : src_i.osc; // R5

  // PLL reference; the register holds one bit, the auto path a full code
  logic [2:0] ref_code;
  logic ref_level, ref_valid;
  always_comb begin
    if (auto_setup_i) begin
      ref_code = auto_ref_sel_i; // R2
    end else begin
      ref_code = {2'b00, ref_dsp_reg[REF_SEL_LSB]}; // R1
    end
    ref_valid = 1'b1;
    case (ref_code)
      REF_MPIN: ref_level = src_i.master_pin; // R1
      REF_BPIN: ref_level = src_i.bit_clk_pin; // R1
      REF_OSC: ref_level = src_i.osc; // R3
      REF_GPIN: ref_level = ref_gpin; // R3
      default: begin
        ref_level = 1'b0; // R3
        ref_valid = 1'b0;
      end
    endcase
  end

  // DSP and DAC share one code table
  function automatic logic pick_main(input logic [2:0] code, input clk_sources_t s,
                                     input logic am, input logic gp);
    case (code)
      SRC_AUTO: pick_main = am;
      SRC_PLL: pick_main = s.pll;
      SRC_OSC: pick_main = s.osc;
      SRC_MPIN: pick_main = s.master_pin;
      SRC_BPIN: pick_main = s.bit_clk_pin;
      SRC_GPIN: pick_main = gp;
      default: pick_main = 1'b0;
    endcase
  endfunction : pick_main

  // Oversampling and charge pump share one code table
  function automatic logic pick_aux(input logic [2:0] code, input clk_sources_t s,
                                    input logic am, input logic gp);
    case (code)
      SRC2_DAC: pick_aux = s.dac;
      SRC2_AUTO: pick_aux = am;
      SRC2_PLL: pick_aux = s.pll;
      SRC2_OSC: pick_aux = s.osc;
      SRC2_MPIN: pick_aux = s.master_pin;
      SRC2_BPIN: pick_aux = s.bit_clk_pin;
      SRC2_GPIN: pick_aux = gp;
      default: pick_aux = 1'b0;
    endcase
  endfunction : pick_aux

  logic dsp_level, dac_level, osr_level, pump_level;
  assign dsp_level = pick_main(dsp_sel, src_i, auto_master, dsp_gpin); // R4
  assign dac_level = pick_main(dac_sel, src_i, auto_master, dac_gpin); // R6
  assign osr_level = pick_aux(osr_sel, src_i, auto_master, osr_gpin); // R7
  assign pump_level = pick_aux(pump_sel, src_i, auto_master, pump_gpin); // R8

  // Each destination changes source through a gap, so no shortened pulse leaks out
  // The gap costs four low cycles per change; dividers downstream must tolerate that
  glitch_free_mux u_ref ( // R12
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(ref_code),
    .sel_valid_i(ref_valid),
    .src_level_i(ref_level),
    .clk_o(clk_o.pll_ref)
  );

  // Reserved codes already select a constant low, so these muxes need no valid flag
  glitch_free_mux u_dsp ( // R12
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(dsp_sel),
    .sel_valid_i(1'b1),
    .src_level_i(dsp_level),
    .clk_o(clk_o.dsp)
  );

  glitch_free_mux u_dac ( // R12
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(dac_sel),
    .sel_valid_i(1'b1),
    .src_level_i(dac_level),
    .clk_o(clk_o.dac)
  );

  glitch_free_mux u_osr ( // R12
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(osr_sel),
    .sel_valid_i(1'b1),
    .src_level_i(osr_level),
    .clk_o(clk_o.oversample)
  );

  glitch_free_mux u_pump ( // R12
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(pump_sel),
    .sel_valid_i(1'b1),
    .src_level_i(pump_level),
    .clk_o(clk_o.pump)
  );

endmodule : clock_source_select

// [verif/clock_source_select_chk.sv]
// Checker: port assertions for the clock source selector
`timescale 1ns/10ps
module clock_source_select_chk
  import clock_source_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire clk_sources_t src_i,
  input wire logic auto_setup_i,
  input wire logic [2:0] auto_ref_sel_i,
  input wire logic master_present_i,
  input wire clk_outputs_t clk_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Edges the auto reference code has stood still; a change inside an earlier gap
  // is taken at the end of that gap and gets no gap of its own, so the gap check only follows a settled code
  logic [2:0] quiet_cnt, prev_sel;
  logic prev_auto;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_cnt <= 3'h0;
      prev_sel <= 3'h0;
      prev_auto <= 1'b0;
    end else begin
      prev_sel <= auto_ref_sel_i;
      prev_auto <= auto_setup_i;
      if (!auto_setup_i || !prev_auto || auto_ref_sel_i != prev_sel) begin
        quiet_cnt <= 3'h0;
      end else if (quiet_cnt != 3'h7) begin
        quiet_cnt <= quiet_cnt + 3'h1;
      end
    end
  end

  a_ref_resv_zero: assert property (
    req_i.rd && req_i.addr == ADDR_PLL_REF_DSP |=> (rdata_o & 8'he8) == 8'h00)
    else $error("reserved bits of pll ref register read nonzero");
  a_two_resv_zero: assert property (
    req_i.rd && req_i.addr inside {8'h0e, 8'h10, 8'h11} |=> (rdata_o & 8'h88) == 8'h00)
    else $error("reserved bits of two field register read nonzero");
  a_low_resv_zero: assert property (
    req_i.rd && req_i.addr inside {8'h0f, 8'h12} |=> rdata_o[7:3] == 5'h00)
    else $error("reserved bits of low field register read nonzero");
  a_field_readback: assert property (
    req_i.wr && req_i.addr inside {8'h0e, 8'h10, 8'h11} ##1 !req_i.wr ##1
    req_i.rd && !req_i.wr && req_i.addr == $past(req_i.addr, 2)
    |=> rdata_o == ($past(req_i.wdata, 3) & MASK_TWO_FIELDS))
    else $error("field readback differs from written value");
  a_auto_osc_ref: assert property (
    (auto_setup_i && auto_ref_sel_i == REF_OSC) [*8] |=> clk_o.pll_ref == $past(src_i.osc))
    else $error("auto mode oscillator reference not followed");
  a_auto_bpin_ref: assert property (
    (auto_setup_i && auto_ref_sel_i == REF_BPIN) [*8]
    |=> clk_o.pll_ref == $past(src_i.bit_clk_pin))
    else $error("auto mode bit clock reference not followed");
  a_auto_mute_ref: assert property (
    (auto_setup_i && auto_ref_sel_i[2]) [*2] |=> !clk_o.pll_ref)
    else $error("reserved auto reference code not muted");
  a_switch_gap: assert property (
    auto_setup_i && quiet_cnt >= 3'h3 && $changed(auto_ref_sel_i)
    |-> ##2 !clk_o.pll_ref [*3])
    else $error("pll reference not gated low across source change");
endmodule : clock_source_select_chk

bind clock_source_select clock_source_select_chk u_chk (.clk_i, .rst_n_i, .req_i, .rdata_o,
  .src_i, .auto_setup_i, .auto_ref_sel_i, .master_present_i, .clk_o);

// [verif/tb_top.sv]
// Testbench: register port and destination clock checks for the selector
`timescale 1ns/10ps
module tb_top;
  import clock_source_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i, auto_setup_i, master_present_i;
  logic [2:0] auto_ref_sel_i, k;
  logic [7:0] rdata_o;
  // Defined before the first falling edge, or the pattern would start unknown
  logic [7:0] cnt = 8'h00;
  logic [7:0] sh [7];
  logic [7:0] mk [7];
  reg_req_t req_i;
  clk_sources_t src_i;
  clk_outputs_t clk_o;
  int err_total, samples_checked;

  clock_source_select u_dut (.clk_i, .rst_n_i, .req_i, .rdata_o, .src_i, .auto_setup_i,
    .auto_ref_sel_i, .master_present_i, .clk_o);

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Distinct patterns per source so a wrong pick shows within a few cycles
  always @(negedge clk_i) begin
    cnt <= cnt + 8'h01;
  end
  assign src_i = {cnt[0], cnt[1], cnt[2], cnt[3], ~cnt[0], cnt[0] ^ cnt[2]};

  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk8

  task automatic chkc(clk_outputs_t e);
    samples_checked++;
    if (clk_o !== e) begin
      err_total++;
      $display("[FAIL] clk_o exp %b got %b", e, clk_o);
    end
  endtask : chkc

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_i);
    req_i = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    req_i = '0;
    if (a inside {[8'h0d:8'h13]}) sh[a - 8'h0d] = d & mk[a - 8'h0d];
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(negedge clk_i);
    req_i = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    req_i = '0;
    chk8($sformatf("reg %h", a), sh[a - 8'h0d], rdata_o);
  endtask : rd

  // Level each output should show, from what was sampled at the last rising edge
  function automatic clk_outputs_t expo();
    logic so, am;
    logic [4:0] b;
    logic [7:0] v;
    clk_outputs_t e;
    so = src_i.serial_out_pin;
    am = master_present_i ? src_i.pll | src_i.master_pin : src_i.osc;
    b = {src_i.bit_clk_pin, src_i.master_pin, src_i.osc, src_i.pll, am};
    v = {4'h0, sh[5][2:0] == PIN_SERIAL_OUT & so, src_i.osc, src_i.bit_clk_pin, src_i.master_pin};
    e.pll_ref = v[auto_setup_i ? auto_ref_sel_i : {2'b00, sh[0][REF_SEL_LSB]}];
    v = {2'b00, sh[3][6:4] == PIN_SERIAL_OUT & so, b};
    e.dsp = v[sh[0][2:0]];
    v = {2'b00, sh[3][2:0] == PIN_SERIAL_OUT & so, b};
    e.dac = v[sh[1][6:4]];
    v = {1'b0, sh[4][2:0] == PIN_SERIAL_OUT & so, b, src_i.dac};
    e.oversample = v[sh[1][2:0]];
    v = {1'b0, sh[4][6:4] == PIN_SERIAL_OUT & so, b, src_i.dac};
    e.pump = v[sh[2][2:0]];
    return e;
  endfunction : expo

  task automatic run(int n);
    repeat (n) begin
      @(negedge clk_i);
      chkc(expo());
    end
  endtask : run

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    err_total++;
    $display("[FAIL] watchdog exp done got hang");
    report_and_stop();
  end

  initial begin
    rst_n_i = 1'b0;
    req_i = '0;
    auto_setup_i = 1'b0;
    auto_ref_sel_i = 3'h0;
    master_present_i = 1'b1;
    mk = '{MASK_PLL_REF_DSP, MASK_TWO_FIELDS, MASK_LOW_FIELD, MASK_TWO_FIELDS,
      MASK_TWO_FIELDS, MASK_LOW_FIELD, 8'h00};
    foreach (sh[i]) sh[i] = REG_RESET;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 7; i++) rd(8'h0d + 8'(i));
    run(8);
    for (int i = 0; i < 7; i++) begin
      wr(8'h0d + 8'(i), 8'hff);
      rd(8'h0d + 8'(i));
    end
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        k = 3'(c);
        master_present_i = k[1];
        wr(8'h10, p == 0 ? 8'h55 : {1'b0, k, 1'b0, k});
        wr(8'h11, p == 0 ? 8'h55 : {1'b0, k, 1'b0, k});
        wr(8'h12, p == 0 ? 8'h05 : {5'h00, k});
        wr(8'h0e, {1'b0, k, 1'b0, k});
        wr(8'h0f, {5'h00, k});
        wr(8'h0d, {3'h0, k[0], 1'b0, k});
        repeat (3) begin
          @(negedge clk_i);
          chk8("dsp gap", 8'h00, {7'h00, clk_o.dsp});
        end
        repeat (2) @(negedge clk_i);
        run(8);
      end
    end
    $display("test source codes done");
    auto_setup_i = 1'b1;
    wr(8'h12, 8'h05);
    for (int c = 0; c < 8; c++) begin
      auto_ref_sel_i = 3'(c);
      wr(8'h0d, c[0] ? 8'h00 : 8'h10);
      repeat (4) @(negedge clk_i);
      run(8);
    end
    $display("test auto setup done");
    report_and_stop();
  end
endmodule : tb_top
